// [dv/pwm_duty_update_override_monitor.sv]
// Checker of duty update and override timing at the generator ports.
// Assumes a bind onto the generator top module.
`timescale 1ns/1ns
module pwm_duty_update_override_monitor
(
	input wire logic        i_sys_clk,
	input wire logic        i_rst_n,
	input wire logic [15:0] i_generator_control,
	input wire logic [1:0]  i_output_mode,
	input wire logic        i_override_sync,
	input wire logic [15:0] i_local_duty_value,
	input wire logic        i_local_duty_wr,
	input wire logic [15:0] i_master_duty_value,
	input wire logic        i_master_duty_wr,
	input wire logic [1:0]  i_override_enable,
	input wire logic [1:0]  i_override_output_value,
	input wire logic        o_pwm_high,
	input wire logic        o_pwm_low,
	input wire logic [15:0] o_active_duty,
	input wire logic        o_boundary
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	a_imm_local_duty: assert property (
		i_generator_control[0] && !i_generator_control[8] && i_local_duty_wr
		|=> o_active_duty == $past(i_local_duty_value)) else $error("local duty late");
	a_imm_master_duty: assert property (
		i_generator_control[0] && i_generator_control[8] && i_master_duty_wr
		|=> o_active_duty == $past(i_master_duty_value)) else $error("master duty late");
	a_unselected_ignored: assert property (
		i_generator_control[0] && i_generator_control[8] && i_local_duty_wr && !i_master_duty_wr
		|=> $stable(o_active_duty)) else $error("unselected duty taken");
	a_shadow_at_boundary: assert property (
		!i_generator_control[0] ##1 $changed(o_active_duty) |-> o_boundary)
		else $error("shadow moved off boundary");
	a_override_next_clk: assert property (
		!i_override_sync && i_override_enable == 2'h3
		|=> {o_pwm_high, o_pwm_low} == $past(i_override_output_value))
		else $error("override late");
	a_pushpull_one_pin: assert property (
		$past(i_output_mode) == pwm_duty_pkg::MODE_PUSHPULL && $past(i_override_enable) == 2'h0
		|-> !(o_pwm_high && o_pwm_low)) else $error("push-pull both pins");
endmodule

// [dv/pwm_duty_update_override_tb.sv]
// Self-checking bench of the duty update and override generator.
// Assumes period 8, stimulus on the falling edge.
`timescale 1ns/1ns
module pwm_duty_update_override_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] gctl = 16'h0001;
	logic [15:0] tctl = 16'h0000;
	logic [1:0]  mode = 2'h0;
	logic        osync = 1'b0;
	logic [15:0] ldv = 16'h0000;
	logic        lwr = 1'b0;
	logic [15:0] mdv = 16'h0000;
	logic        mwr = 1'b0;
	logic [1:0]  oen = 2'h0;
	logic [1:0]  oval = 2'h0;
	logic        ph;
	logic        pl;
	logic        bnd;
	logic        node;
	logic        shoot;
	logic [15:0] act;
	int          err_total = 0;
	int          checked = 0;
	int          nh;
	int          nl;
	pwm_duty_update_override u_pwm_duty_update_override (.i_sys_clk(clk), .i_rst_n(rst_n),
		.i_generator_control(gctl), .i_time_base_control(tctl), .i_output_mode(mode),
		.i_override_sync(osync), .i_period(16'h0008), .i_local_duty_value(ldv),
		.i_local_duty_wr(lwr), .i_master_duty_value(mdv), .i_master_duty_wr(mwr),
		.i_override_enable(oen), .i_override_output_value(oval), .o_pwm_high(ph),
		.o_pwm_low(pl), .o_active_duty(act), .o_boundary(bnd));
	pwm_stage_model u_pwm_stage_model (.i_sys_clk(clk), .i_high(ph), .i_low(pl),
		.o_node(node), .o_shoot(shoot));
	initial
	begin
		forever #10 clk = ~clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("mismatches %0d, comparisons %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// One strobe per write; the other source holds a different value
	task automatic wr(input logic mst, input logic [15:0] v);
		@(negedge clk);
		ldv = mst ? ~v : v;
		mdv = mst ? v : ~v;
		lwr = !mst;
		mwr = mst;
		@(negedge clk);
		lwr = 1'b0;
		mwr = 1'b0;
	endtask
	task automatic wait_bnd();
		for (int i = 0; i < 40; i++)
		begin
			@(negedge clk);
			if (bnd === 1'b1)
				return;
		end
		err_total++;
		print_verdict();
	endtask
	initial
	begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		tctl = 16'h8000;
		wr(1'b0, 16'h0003);
		check(act, 16'h0003);
		gctl = 16'h0101;
		wr(1'b1, 16'h0005);
		check(act, 16'h0005);
		wr(1'b0, 16'h0033);
		check(act, 16'h0005);
		gctl = 16'h0000;
		wait_bnd();
		wr(1'b0, 16'h0002);
		check(act, 16'h0005);
		wait_bnd();
		check(act, 16'h0002);
		// Override with CPU-clock sync, each pin pattern taken at the next clock
		wait_bnd();
		oen = 2'h3;
		oval = 2'h2;
		@(negedge clk);
		check({14'h0, ph, pl}, 16'h0002);
		oval = 2'h1;
		@(negedge clk);
		check({14'h0, ph, pl}, 16'h0001);
		oen = 2'h0;
		mode = pwm_duty_pkg::MODE_PUSHPULL;
		wait_bnd();
		wait_bnd();
		nh = 0;
		nl = 0;
		// Two whole periods: each pulse on one pin only, pins alternate
		for (int i = 0; i < 16; i++)
		begin
			nh += ph;
			nl += pl;
			check({15'h0, shoot}, 16'h0000);
			if (i == 7)
				check(16'(nh * nl), 16'h0000);
			@(negedge clk);
		end
		check(nh[15:0], 16'h0002);
		check(nl[15:0], 16'h0002);
		// Shadowed nonzero-to-zero change in redundant mode shows the glitch
		mode = pwm_duty_pkg::MODE_REDUNDANT;
		wait_bnd();
		wr(1'b0, 16'h0000);
		wait_bnd();
		check(act, 16'h0000);
		@(negedge clk);
		check({14'h0, ph, pl}, 16'h0003);
		@(negedge clk);
		check({14'h0, ph, pl}, 16'h0000);
		print_verdict();
	end
endmodule
bind pwm_duty_update_override pwm_duty_update_override_monitor u_mon (.*);

// [dv/pwm_stage_model.sv]
// Switching stage on the two pins: node level and shoot-through flag.
// Assumes pins sampled on the system clock.
`timescale 1ns/1ns
module pwm_stage_model
(
	input  wire logic i_sys_clk,
	input  wire logic i_high,
	input  wire logic i_low,
	output logic      o_node = 1'b0,
	output logic      o_shoot
);
	// Undriven node toggles so a stale level never passes for drive
	always_ff @(posedge i_sys_clk)
	begin
		o_node <= i_high ? 1'b1 : (i_low ? 1'b0 : ~o_node);
	end
	assign o_shoot = i_high & i_low;
endmodule

// [hdl/pwm_duty_pkg.sv]
// Constants shared by the duty-update and override PWM generator files.
// Assumes a single system clock; one PWM clock equals one system clock.
package pwm_duty_pkg;
	localparam int        DUTY_W          = 16;
	localparam int        MODE_W          = 2;
	localparam int        OVR_W           = 2;
	// Output-mode field encodings
	localparam logic [1:0] MODE_REDUNDANT = 2'h2;
	localparam logic [1:0] MODE_PUSHPULL  = 2'h1;
	localparam logic [1:0] MODE_COMPL     = 2'h0;
	// Control bit positions
	localparam int        IMM_UPD_BIT     = 0;
	localparam int        DUTY_SRC_BIT    = 8;
	localparam int        MOD_EN_BIT      = 15;
	localparam int        OVR_SYNC_BIT    = 0;
	// Reset values
	localparam logic [15:0] PERIOD_RST    = 16'h0064;
	localparam logic [15:0] DUTY_RST      = 16'h0000;
	localparam logic [1:0]  OVR_RST       = 2'h0;
endpackage

// [hdl/pwm_duty_update_override.sv]
// PWM generator: duty source select, immediate/shadowed duty update,
// output-mode steering and CPU-clock or period-synchronised override.
// Assumes control ports are written synchronously by the CPU side.
//
// Behaviour
// - Mode field 10 selects redundant, 01 selects push-pull output.
// - Control bit 0 set makes duty writes affect output immediately.
// - Control bit 8 picks local duty (0) or master duty (1).
// - Nonzero-to-zero shadowed duty change in redundant or push-pull mode gives one-clock glitch at boundary.
// - Override sync bit 0 clear applies override value at next clock.
`timescale 1ns/1ns
module pwm_duty_update_override
#(
	parameter int DUTY_W = pwm_duty_pkg::DUTY_W
)
(
	input  wire logic              i_sys_clk,
	input  wire logic              i_rst_n,
	input  wire logic [15:0]       i_generator_control,
	input  wire logic [15:0]       i_time_base_control,
	input  wire logic [1:0]        i_output_mode,
	input  wire logic              i_override_sync,
	input  wire logic [DUTY_W-1:0] i_period,
	input  wire logic [DUTY_W-1:0] i_local_duty_value,
	input  wire logic              i_local_duty_wr,
	input  wire logic [DUTY_W-1:0] i_master_duty_value,
	input  wire logic              i_master_duty_wr,
	input  wire logic [1:0]        i_override_enable,
	input  wire logic [1:0]        i_override_output_value,
	output logic                   o_pwm_high,
	output logic                   o_pwm_low,
	output logic [DUTY_W-1:0]      o_active_duty,
	output logic                   o_boundary
);
	typedef struct packed
	{
		logic [DUTY_W-1:0] shadow;
		logic [DUTY_W-1:0] active;
		logic              glitch;
		logic [1:0]        ovr_en;
		logic [1:0]        ovr_val;
		logic              toggle;
		logic              pwm_h;
		logic              pwm_l;
		logic              bnd;
	} st_t;

	st_t               st_r;
	st_t               st_nxt;
	logic [DUTY_W-1:0] count;
	logic              boundary;
	logic              imm_upd;
	logic              src_master;
	logic              enable;
	logic              dwr;
	logic [DUTY_W-1:0] dval;
	logic              raw;

	initial
	begin
		if (DUTY_W < 2 || DUTY_W > 16)
			$error("pwm_duty_update_override: DUTY_W out of range");
	end

	assign imm_upd    = i_generator_control[pwm_duty_pkg::IMM_UPD_BIT];
	assign src_master = i_generator_control[pwm_duty_pkg::DUTY_SRC_BIT];
	// Software must set imm_upd before this; changing it live is not guarded
	assign enable     = i_time_base_control[pwm_duty_pkg::MOD_EN_BIT];

	// Duty source select: only a write to the selected register counts
	assign dwr  = src_master ? i_master_duty_wr : i_local_duty_wr;
	assign dval = src_master ? i_master_duty_value : i_local_duty_value;

	pwm_period_counter
	#(
		.WIDTH      (DUTY_W)
	)
	u_pwm_period_counter
	(
		.i_sys_clk  (i_sys_clk),
		.i_rst_n    (i_rst_n),
		.i_enable   (enable),
		.i_period   (i_period),
		.o_count    (count),
		.o_boundary (boundary)
	);

	// Raw compare; glitch stretches output high for one clock
	assign raw = enable && ((count < st_r.active) || st_r.glitch);

	// Next-state: duty update, override sync and output steering
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.bnd = boundary;
		st_nxt.glitch = 1'b0;
		if (dwr)
			st_nxt.shadow = dval;
		if (imm_upd && dwr)
			st_nxt.active = dval;
		else if (!imm_upd && boundary)
		begin
			st_nxt.active = dwr ? dval : st_r.shadow;
			// Reproduced defect: old duty nonzero, new zero, mode redundant/push-pull
			if ((i_output_mode == pwm_duty_pkg::MODE_REDUNDANT ||
			     i_output_mode == pwm_duty_pkg::MODE_PUSHPULL) &&
			    st_r.active != '0 && st_nxt.active == '0)
				st_nxt.glitch = 1'b1;
		end
		// Override: CPU-clock sync takes the value now, else wait for boundary
		if (!i_override_sync || boundary)
		begin
			st_nxt.ovr_en  = i_override_enable;
			st_nxt.ovr_val = i_override_output_value;
		end
		if (boundary)
			st_nxt.toggle = ~st_r.toggle;
		// Output mode steering
		case (i_output_mode)
			pwm_duty_pkg::MODE_REDUNDANT:
			begin
				st_nxt.pwm_h = raw;
				st_nxt.pwm_l = raw;
			end
			// Use the toggle as it will be after this boundary, so a pulse never splits
			pwm_duty_pkg::MODE_PUSHPULL:
			begin
				st_nxt.pwm_h = raw && !(st_r.toggle ^ boundary);
				st_nxt.pwm_l = raw && (st_r.toggle ^ boundary);
			end
			pwm_duty_pkg::MODE_COMPL:
			begin
				st_nxt.pwm_h = raw;
				st_nxt.pwm_l = enable && !raw;
			end
			default:
			begin
				st_nxt.pwm_h = raw;
				st_nxt.pwm_l = 1'b0;
			end
		endcase
		// Override has priority over the generated waveform
		if (st_nxt.ovr_en[1])
			st_nxt.pwm_h = st_nxt.ovr_val[1];
		if (st_nxt.ovr_en[0])
			st_nxt.pwm_l = st_nxt.ovr_val[0];
	end

	// Single state register
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_r         <= '0;
			st_r.shadow  <= DUTY_W'(pwm_duty_pkg::DUTY_RST);
			st_r.active  <= DUTY_W'(pwm_duty_pkg::DUTY_RST);
			st_r.ovr_val <= pwm_duty_pkg::OVR_RST;
		end
		else
			st_r <= st_nxt;
	end

	assign o_pwm_high    = st_r.pwm_h;
	assign o_pwm_low     = st_r.pwm_l;
	assign o_active_duty = st_r.active;
	assign o_boundary    = st_r.bnd;
endmodule

// [hdl/pwm_period_counter.sv]
// Period time base: counts 0..period-1 and flags the period boundary.
// Assumes period is held stable by software while running.
`timescale 1ns/1ns
module pwm_period_counter
#(
	parameter int WIDTH = 16
)
(
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_enable,
	input  wire logic [WIDTH-1:0] i_period,
	output logic      [WIDTH-1:0] o_count,
	output logic                  o_boundary
);
	typedef struct packed
	{
		logic [WIDTH-1:0] cnt;
		logic             bnd;
	} st_t;

	st_t st_r;
	st_t st_nxt;

	initial
	begin
		if (WIDTH < 2)
			$error("pwm_period_counter: WIDTH too small");
	end

	// Roll over at period-1; boundary pulses in the cycle the count is zero
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.bnd = 1'b0;
		if (!i_enable)
			st_nxt.cnt = '0;
		else if (st_r.cnt >= i_period - WIDTH'(1))
		begin
			st_nxt.cnt = '0;
			st_nxt.bnd = 1'b1;
		end
		else
			st_nxt.cnt = st_r.cnt + WIDTH'(1);
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign o_count    = st_r.cnt;
	assign o_boundary = st_r.bnd;
endmodule
